// [src/usb_test_pkg.sv]
package usb_test_pkg;

  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [8:0] TEST_CTRL_OFS   = 9'h106;
  localparam logic [8:0] CH_FIFO_CTL_OFS = 9'h108;
  localparam logic [8:0] PAYLOAD_OFS     = 9'h1f0;
  localparam logic [8:0] STATUS_OFS      = 9'h1f1;
  localparam logic [8:0] FILL_OFS        = 9'h1f2;

  // Test control fields and values
  localparam int         ARM_BIT       = 7;
  localparam int         FORCE_BIT     = 4;
  localparam int         RX_HOLD_BIT   = 3;
  localparam int         J_BIT         = 2;
  localparam int         K_BIT         = 1;
  localparam int         PKT_BIT       = 0;
  localparam logic [7:0] MODE_MASK     = 8'h1f;
  localparam logic [7:0] CTRL_WR_MASK  = 8'h9f;
  localparam logic [7:0] TEST_CTRL_RST = 8'h00;
  localparam logic [7:0] TEST_EXIT_VAL = 8'h00;

  // Channel FIFO control fields
  localparam int AREA_CLR_BIT = 0;
  localparam int ALL_CLR_BIT = 5;

  // Status fields
  localparam int ST_READY_BIT = 7;
  localparam int ST_OVFL_BIT  = 6;
  localparam int ST_ACT_BIT   = 5;
  localparam int ST_TX_BIT    = 4;

  // Packet framing
  localparam logic [7:0]  PID_DATA0 = 8'hc3;
  localparam logic [15:0] CRC_INIT  = 16'hffff;
  localparam logic [15:0] CRC_POLY  = 16'ha001;

  // Sizes
  localparam logic [6:0] AREA_BYTES = 7'h40;
  localparam int         AREA_DEPTH = 64;
  localparam int         FIFO_DEPTH = 8;

  // Host port state codes
  typedef logic [2:0] host_state_t;
  localparam host_state_t HOST_IDLE         = 3'h0;
  localparam host_state_t HOST_WAIT_CONNECT = 3'h1;
  localparam host_state_t HOST_DISABLED     = 3'h2;
  localparam host_state_t HOST_SUSPEND      = 3'h3;

  typedef enum {MODE_NONE, MODE_FORCE, MODE_RX_HOLD, MODE_J, MODE_K,
                MODE_PKT} test_mode_t;
  typedef enum {TX_IDLE, TX_PID, TX_DATA, TX_CRC_LO, TX_CRC_HI,
                TX_END} tx_state_t;

endpackage

// [src/byte_stream_if.sv]
interface byte_stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// [src/payload_fifo.sv]
module payload_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic    clk_sys,
  input wire logic    nrst,
  input wire logic    clr,
  byte_stream_if.snk  in_s,
  byte_stream_if.src  out_s
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_q, wp_d;
  logic [AW-1:0]    rp_q, rp_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push;
  logic             pop;

  assign in_s.ready  = cnt_q != FULL_CNT;
  assign out_s.valid = cnt_q != '0;
  assign out_s.data  = mem[rp_q];
  assign push        = in_s.valid & in_s.ready;
  assign pop         = out_s.valid & out_s.ready;

  always_comb
  begin
    wp_d  = wp_q;
    rp_d  = rp_q;
    cnt_d = cnt_q;
    if (clr)
    begin
      wp_d  = '0;
      rp_d  = '0;
      cnt_d = '0;
    end
    else
    begin
      if (push)
        wp_d = (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
      if (pop)
        rp_d = (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem[wp_q] <= in_s.data;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end
endmodule

// [src/usb_crc16.sv]
module usb_crc16 (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        init,
  input  wire logic        en,
  input  wire logic [7:0]  byte_in,
  output logic      [15:0] crc
);
  import usb_test_pkg::*;

  logic [15:0] crc_q, crc_d;

  // Reflected CRC-16 over one byte, LSB first as on the wire
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0]  b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    return r;
  endfunction

  assign crc = crc_q;

  always_comb
  begin
    crc_d = crc_q;
    if (init)
      crc_d = CRC_INIT;
    else if (en)
      crc_d = crc_step(crc_q, byte_in);
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      crc_q <= CRC_INIT;
    else
      crc_q <= crc_d;
  end
endmodule

// [src/usb_host_test_mode_control.sv]
// Design decision made here: the plain strobed port.
module usb_host_test_mode_control (
  input  wire logic                      clk_sys,
  input  wire logic                      nrst,
  input  wire logic [8:0]                reg_addr,
  input  wire logic [7:0]                reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [7:0]                reg_rdata,
  input  wire usb_test_pkg::host_state_t host_state,
  input  wire logic                      tx_ready,
  output logic                           tx_valid,
  output logic      [7:0]                tx_data,
  output logic                           tx_last,
  output logic                           sof_enable,
  output logic                           rx_hold,
  output logic                           drive_j,
  output logic                           drive_k,
  output logic                           test_active,
  output logic                           host_to_idle
);
  import usb_test_pkg::*;

  byte_stream_if #(.W(8)) fill_s ();
  byte_stream_if #(.W(8)) drain_s ();

  logic [7:0]  area [AREA_DEPTH];
  logic [7:0]  ctrl_q, ctrl_d;
  test_mode_t  mode_q, mode_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        ovfl_q, ovfl_d;
  logic [6:0]  fill_q, fill_d;
  logic        area_clr;
  logic        area_wr;
  logic        sof_q, sof_d;
  logic        rxh_q, rxh_d;
  logic        j_q, j_d;
  logic        k_q, k_d;
  logic        act_q, act_d;
  logic        idle_q, idle_d;
  tx_state_t   tx_q, tx_d;
  logic [6:0]  idx_q, idx_d;
  logic        txv_q, txv_d;
  logic [7:0]  txb_q, txb_d;
  logic        txl_q, txl_d;
  logic        accept;
  logic        crc_init;
  logic        crc_en;
  logic [15:0] crc;

  function automatic logic entry_ok(input host_state_t s);
    return (s == HOST_WAIT_CONNECT) || (s == HOST_DISABLED) ||
           (s == HOST_SUSPEND);
  endfunction

  // Highest set bit wins if several mode bits are armed together
  function automatic test_mode_t decode_mode(input logic [7:0] v);
    if (v[FORCE_BIT])
      return MODE_FORCE;
    else if (v[RX_HOLD_BIT])
      return MODE_RX_HOLD;
    else if (v[J_BIT])
      return MODE_J;
    else if (v[K_BIT])
      return MODE_K;
    else if (v[PKT_BIT])
      return MODE_PKT;
    else
      return MODE_NONE;
  endfunction

  // Payload writes enter the FIFO; a full FIFO refuses them
  assign fill_s.valid  = reg_wr && (reg_addr == PAYLOAD_OFS);
  assign fill_s.data   = reg_wdata;
  // Area stops draining while the packet is being sent
  assign drain_s.ready = (fill_q != AREA_BYTES) && (mode_q != MODE_PKT);
  assign area_wr       = drain_s.valid & drain_s.ready;
  assign accept        = txv_q & tx_ready;

  payload_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .clr     (area_clr),
    .in_s    (fill_s),
    .out_s   (drain_s)
  );

  usb_crc16 u_crc (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .init    (crc_init),
    .en      (crc_en),
    .byte_in (txb_q),
    .crc     (crc)
  );

  // Control register, mode selection and FIFO clear
  always_comb
  begin
    ctrl_d   = ctrl_q;
    mode_d   = mode_q;
    idle_d   = 1'b0;
    area_clr = 1'b0;
    ovfl_d   = ovfl_q;
    if (reg_wr && reg_addr == TEST_CTRL_OFS)
    begin
      if (reg_wdata == TEST_EXIT_VAL)
      begin
        ctrl_d = TEST_CTRL_RST;
        mode_d = MODE_NONE;
        idle_d = mode_q != MODE_NONE;
      end
      else if (mode_q == MODE_NONE)
      begin
        ctrl_d = reg_wdata & CTRL_WR_MASK;
        // Packet bit may be stored first, but the arming write must carry the mode bit again
        if (reg_wdata[ARM_BIT] && (reg_wdata & MODE_MASK) != 8'h00 &&
            entry_ok(host_state))
          mode_d = decode_mode(reg_wdata);
      end
    end
    else if (reg_wr && reg_addr == CH_FIFO_CTL_OFS)
    begin
      // Clearing is ignored while the payload is in use
      if ((reg_wdata[AREA_CLR_BIT] || reg_wdata[ALL_CLR_BIT]) &&
          mode_q != MODE_PKT)
        area_clr = 1'b1;
    end
    else if (reg_wr && reg_addr == STATUS_OFS && reg_wdata[ST_OVFL_BIT])
      ovfl_d = 1'b0;
    // A refused payload write sets the flag even while it is cleared
    if (fill_s.valid && !fill_s.ready)
      ovfl_d = 1'b1;
  end

  // Line state controls follow the mode
  always_comb
  begin
    sof_d = mode_d == MODE_FORCE;
    rxh_d = mode_d == MODE_RX_HOLD;
    j_d   = mode_d == MODE_J;
    k_d   = mode_d == MODE_K;
    act_d = mode_d != MODE_NONE;
  end

  // Channel zero payload area fill level
  always_comb
  begin
    fill_d = fill_q;
    if (area_clr)
      fill_d = '0;
    else if (area_wr)
      fill_d = fill_q + 7'h01;
  end

  // Register read data, one cycle after the strobe
  always_comb
  begin
    rdata_d = 8'h00;
    if (reg_rd)
    begin
      if (reg_addr == TEST_CTRL_OFS)
        rdata_d = ctrl_q;
      else if (reg_addr == STATUS_OFS)
      begin
        rdata_d[ST_READY_BIT] = fill_s.ready;
        rdata_d[ST_OVFL_BIT]  = ovfl_q;
        rdata_d[ST_ACT_BIT]   = act_q;
        rdata_d[ST_TX_BIT]    = tx_q != TX_IDLE;
      end
      else if (reg_addr == FILL_OFS)
        rdata_d = {1'b0, fill_q};
    end
  end

  // Test packet sender: PID, channel zero payload, CRC16, repeated
  always_comb
  begin
    tx_d     = tx_q;
    idx_d    = idx_q;
    txv_d    = txv_q;
    txb_d    = txb_q;
    txl_d    = txl_q;
    crc_init = 1'b0;
    crc_en   = 1'b0;
    if (mode_q != MODE_PKT)
    begin
      tx_d  = TX_IDLE;
      txv_d = 1'b0;
      txl_d = 1'b0;
    end
    else
    begin
      case (tx_q)
        TX_IDLE:
        begin
          if (fill_q != 7'h00)
          begin
            txv_d    = 1'b1;
            txb_d    = PID_DATA0;
            txl_d    = 1'b0;
            idx_d    = '0;
            crc_init = 1'b1;
            tx_d     = TX_PID;
          end
        end
        TX_PID:
        begin
          if (accept)
          begin
            txb_d = area[idx_q[5:0]];
            idx_d = idx_q + 7'h01;
            tx_d  = TX_DATA;
          end
        end
        TX_DATA:
        begin
          if (accept)
          begin
            crc_en = 1'b1;
            if (idx_q == fill_q)
            begin
              // Wait one cycle for the last byte to reach the CRC
              txv_d = 1'b0;
              tx_d  = TX_CRC_LO;
            end
            else
            begin
              txb_d = area[idx_q[5:0]];
              idx_d = idx_q + 7'h01;
            end
          end
        end
        TX_CRC_LO:
        begin
          txv_d = 1'b1;
          txb_d = ~crc[7:0];
          tx_d  = TX_CRC_HI;
        end
        TX_CRC_HI:
        begin
          if (accept)
          begin
            txb_d = ~crc[15:8];
            txl_d = 1'b1;
            tx_d  = TX_END;
          end
        end
        TX_END:
        begin
          if (accept)
          begin
            txv_d = 1'b0;
            txl_d = 1'b0;
            tx_d  = TX_IDLE;
          end
        end
        default:
          tx_d = TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (area_wr)
      area[fill_q[5:0]] <= drain_s.data;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_q  <= TEST_CTRL_RST;
      mode_q  <= MODE_NONE;
      rdata_q <= 8'h00;
      ovfl_q  <= 1'b0;
      fill_q  <= '0;
      sof_q   <= 1'b0;
      rxh_q   <= 1'b0;
      j_q     <= 1'b0;
      k_q     <= 1'b0;
      act_q   <= 1'b0;
      idle_q  <= 1'b0;
      tx_q    <= TX_IDLE;
      idx_q   <= '0;
      txv_q   <= 1'b0;
      txb_q   <= 8'h00;
      txl_q   <= 1'b0;
    end
    else
    begin
      ctrl_q  <= ctrl_d;
      mode_q  <= mode_d;
      rdata_q <= rdata_d;
      ovfl_q  <= ovfl_d;
      fill_q  <= fill_d;
      sof_q   <= sof_d;
      rxh_q   <= rxh_d;
      j_q     <= j_d;
      k_q     <= k_d;
      act_q   <= act_d;
      idle_q  <= idle_d;
      tx_q    <= tx_d;
      idx_q   <= idx_d;
      txv_q   <= txv_d;
      txb_q   <= txb_d;
      txl_q   <= txl_d;
    end
  end

  assign reg_rdata    = rdata_q;
  assign tx_valid     = txv_q;
  assign tx_data      = txb_q;
  assign tx_last      = txl_q;
  assign sof_enable   = sof_q;
  assign rx_hold      = rxh_q;
  assign drive_j      = j_q;
  assign drive_k      = k_q;
  assign test_active  = act_q;
  assign host_to_idle = idle_q;

endmodule

// [tb/usb_test_properties.sv]
module usb_test_properties (
  input wire logic                      clk_sys,
  input wire logic                      nrst,
  input wire logic [8:0]                reg_addr,
  input wire logic [7:0]                reg_wdata,
  input wire logic                      reg_wr,
  input wire usb_test_pkg::host_state_t host_state,
  input wire logic                      tx_ready,
  input wire logic                      tx_valid,
  input wire logic [7:0]                tx_data,
  input wire logic                      tx_last,
  input wire logic                      sof_enable,
  input wire logic                      rx_hold,
  input wire logic                      drive_j,
  input wire logic                      drive_k,
  input wire logic                      test_active,
  input wire logic                      host_to_idle
);
  timeunit 1ns;
  timeprecision 1ns;
  import usb_test_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic cw;
  logic ok;
  logic go;
  assign cw = reg_wr && reg_addr == TEST_CTRL_OFS;
  assign ok = host_state inside {HOST_WAIT_CONNECT, HOST_DISABLED,
                                 HOST_SUSPEND};
  assign go = cw && ok && !test_active;
  entry_state_a:
    assert property (cw && reg_wdata[7] && !ok && !test_active
      |=> !test_active) else $error("mode entered from wrong state");
  enter_mode_a:
    assert property (go && reg_wdata[7] && (reg_wdata & MODE_MASK) != 0
      |=> test_active) else $error("armed mode not entered");
  force_mode_a:
    assert property (go && reg_wdata == 8'h90 |=> sof_enable && !drive_j)
      else $error("forced enable mode wrong");
  rx_hold_a:
    assert property (go && reg_wdata == 8'h88 |=> rx_hold && !sof_enable)
      else $error("receive hold mode wrong");
  j_state_a:
    assert property (go && reg_wdata == 8'h84 |=> drive_j && !drive_k)
      else $error("j mode wrong");
  k_state_a:
    assert property (go && reg_wdata == 8'h82 |=> drive_k && !drive_j)
      else $error("k mode wrong");
  exit_idle_a:
    assert property (cw && reg_wdata == 8'h00 && test_active
      |=> !test_active && host_to_idle ##1 !host_to_idle)
      else $error("exit did not end mode");
  tx_gate_a:
    assert property (!test_active |=> !tx_valid)
      else $error("packet sent outside mode");
  tx_hold_a:
    assert property (tx_valid && !tx_ready && test_active
      |=> tx_valid && $stable(tx_data)) else $error("byte not held");
  pkt_gap_a:
    assert property (tx_valid && tx_ready && tx_last |=> !tx_valid)
      else $error("no gap after packet");
  cover property (go && reg_wdata == 8'h81);
  cover property (tx_valid && tx_ready && tx_last);
  cover property (host_to_idle);
endmodule

bind usb_host_test_mode_control usb_test_properties usb_test_properties_inst (
  .clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr, .host_state, .tx_ready,
  .tx_valid, .tx_data, .tx_last, .sof_enable, .rx_hold, .drive_j, .drive_k,
  .test_active, .host_to_idle);

// [tb/usb_fixture.sv]
module usb_fixture (
  input  wire logic       clk_sys,
  input  wire logic       slow,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  output logic            tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  logic       lst[$];
  // Slow fixture stalls every other cycle
  always @(posedge clk_sys)
  begin
    if (tx_valid && tx_ready)
    begin
      got.push_back(tx_data);
      lst.push_back(tx_last);
    end
    tx_ready <= slow ? !tx_ready : 1'b1;
  end
endmodule

// [tb/tb.sv]
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import usb_test_pkg::*;
  logic        clk_sys, nrst, reg_wr, reg_rd, slow, tx_ready, tx_valid;
  logic        tx_last, sof_enable, rx_hold, drive_j, drive_k;
  logic        test_active, host_to_idle;
  logic [8:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, tx_data;
  logic [7:0]  pay[53];
  logic [15:0] crc;
  host_state_t host_state;
  int          num_errors, n_compared;

  usb_host_test_mode_control usb_host_test_mode_control_inst (
    .clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .host_state, .tx_ready, .tx_valid, .tx_data, .tx_last, .sof_enable,
    .rx_hold, .drive_j, .drive_k, .test_active, .host_to_idle);
  usb_fixture usb_fixture_inst (.clk_sys, .slow, .tx_valid, .tx_data,
    .tx_last, .tx_ready);

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task end_sim;
    if (num_errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input logic [7:0] g, input logic [7:0] e, input string m);
    n_compared++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [8:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk(reg_rdata, e, "read");
    @(negedge clk_sys);
    chk(reg_rdata, 8'h00, "read idle");
  endtask

  task outs(input logic [3:0] e);
    @(negedge clk_sys);
    chk({4'h0, sof_enable, rx_hold, drive_j, drive_k}, {4'h0, e}, "modes");
  endtask

  task set_state(input host_state_t s);
    @(posedge clk_sys);
    host_state <= s;
  endtask

  task leave;
    wr(TEST_CTRL_OFS, TEST_EXIT_VAL);
    @(negedge clk_sys);
    chk({6'h0, test_active, host_to_idle}, 8'h01, "exit");
    @(negedge clk_sys);
    chk({7'h0, host_to_idle}, 8'h00, "idle pulse");
  endtask

  task t_reset;
    rd(TEST_CTRL_OFS, TEST_CTRL_RST);
    rd(STATUS_OFS, 8'h80);
    rd(9'h107, 8'h00);
  endtask

  task t_modes;
    logic [7:0] code[4] = '{8'h90, 8'h88, 8'h84, 8'h82};
    logic [3:0] ex[4] = '{4'h8, 4'h4, 4'h2, 4'h1};
    for (int i = 0; i < 4; i++)
    begin
      set_state(host_state_t'(1 + i % 3));
      wr(TEST_CTRL_OFS, code[i]);
      outs(ex[i]);
      rd(TEST_CTRL_OFS, code[i]);
      rd(STATUS_OFS, 8'ha0);
      leave();
    end
  endtask

  task t_refuse;
    set_state(HOST_IDLE);
    wr(TEST_CTRL_OFS, 8'h84);
    outs(4'h0);
    set_state(host_state_t'(3'h4));
    wr(TEST_CTRL_OFS, 8'h84);
    outs(4'h0);
    rd(TEST_CTRL_OFS, 8'h84);
    wr(TEST_CTRL_OFS, 8'h00);
    @(negedge clk_sys);
    chk({7'h0, host_to_idle}, 8'h00, "idle without mode");
    set_state(HOST_SUSPEND);
    wr(TEST_CTRL_OFS, 8'h84);
    wr(TEST_CTRL_OFS, 8'h82);
    outs(4'h2);
    rd(TEST_CTRL_OFS, 8'h84);
    leave();
  endtask

  task t_fill;
    wr(CH_FIFO_CTL_OFS, 8'h20);
    for (int i = 0; i < 80; i++)
      wr(PAYLOAD_OFS, 8'(i));
    rd(FILL_OFS, 8'h40);
    rd(STATUS_OFS, 8'h40);
    wr(STATUS_OFS, 8'h40);
    rd(STATUS_OFS, 8'h00);
    wr(CH_FIFO_CTL_OFS, 8'h01);
    rd(FILL_OFS, 8'h00);
    rd(STATUS_OFS, 8'h80);
  endtask

  task t_packet;
    logic [7:0] tail[5] = '{8'hef, 8'hf7, 8'hfb, 8'hfd, 8'h7e};
    crc = CRC_INIT;
    foreach (pay[i])
    begin
      pay[i] = i < 48 ? 8'(i * 5 + 1) : tail[i - 48];
      crc ^= {8'h00, pay[i]};
      repeat (8) crc = crc[0] ? (crc >> 1) ^ CRC_POLY : crc >> 1;
      wr(PAYLOAD_OFS, pay[i]);
    end
    crc = ~crc;
    repeat (3) @(posedge clk_sys);
    rd(FILL_OFS, 8'h35);
    slow <= 1'b1;
    set_state(HOST_DISABLED);
    usb_fixture_inst.got.delete();
    usb_fixture_inst.lst.delete();
    wr(TEST_CTRL_OFS, 8'h01);
    wr(TEST_CTRL_OFS, 8'h81);
    rd(STATUS_OFS, 8'hb0);
    for (int k = 0; k < 2000 && usb_fixture_inst.got.size() < 56; k++)
      @(posedge clk_sys);
    chk(8'(usb_fixture_inst.got.size()), 8'h38, "packet length");
    chk(usb_fixture_inst.got[0], PID_DATA0, "pid");
    for (int i = 0; i < 53; i++)
      chk(usb_fixture_inst.got[i + 1], pay[i], "payload");
    chk(usb_fixture_inst.got[54], crc[7:0], "crc low");
    chk(usb_fixture_inst.got[55], crc[15:8], "crc high");
    chk({7'h0, usb_fixture_inst.lst[54]}, 8'h00, "early last");
    chk({7'h0, usb_fixture_inst.lst[55]}, 8'h01, "last flag");
    leave();
    slow <= 1'b0;
  endtask

  initial
  begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 9'h000;
    reg_wdata = 8'h00;
    host_state = HOST_IDLE;
    slow = 1'b0;
    num_errors = 0;
    n_compared = 0;
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset;
    t_modes;
    t_refuse;
    t_fill;
    t_packet;
    end_sim;
  end

  initial
  begin
    #(20000 * 50);
    num_errors++;
    end_sim;
  end
endmodule
